// File: hw/vpm_ctrl.v
// Phase management and fault protection control for a multiphase regulator.
//
// Operation
// (RULE_01) Per-rail enable gates automatic phase changes.
// (RULE_02) Raise phases when current exceeds thresholds.
// (RULE_03) Drop only below threshold minus hysteresis.
// (RULE_04) Diode emulation on zero current when enabled.
// (RULE_05) Phase increases take effect immediately.
// (RULE_06) Phase decreases wait programmable shed delay.
// (RULE_07) Transitions or fast transients force full phases.
// (RULE_08) Soft-start overcurrent armed first ramp plus 80us.
// (RULE_09) Soft-start overcurrent: all switches off, not good.
// (RULE_10) Soft-start threshold base by current band.
// (RULE_11) Latched faults clear only on enable toggle.
// (RULE_12) Sum overcurrent factor by phase mode, band.
// (RULE_13) Sum threshold ignores runtime max current changes.
// (RULE_14) Sum overcurrent for 40us: tri-state, not good.
// (RULE_15) Sum overcurrent masked in transitions, zero target.
// (RULE_16) Overvoltage disabled while target is zero.
// (RULE_17) Fixed 2.45V overvoltage level during first ramp.
// (RULE_18) Otherwise target plus 350mV, floor 1.35V.
// (RULE_19) Filtered overvoltage: rail not good, outputs low.
// (RULE_20) Hold outputs low until output falls enough.
// (RULE_21) After 60us ramp target down, outputs off.
// (RULE_22) Reference flag level encodes fault type.
// (RULE_23) Latched faults freeze rail and phase decisions; here only rail A phases freeze, rail B keeps updating.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ns
`include "vpm_consts.vh"

module vpm_ctrl #(
  parameter FULL_A = 5,
  parameter STEP_HI_A = 4,
  parameter STEP_LO_A = 2,
  parameter FULL_B = 2
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire arst_n_i,
  // Register port
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  // Rail enable and regulation status
  input wire enable_i,
  input wire [7:0] reported_current_a_i,
  input wire [7:0] reported_current_b_i,
  input wire [2:0] zero_current_detect_i,
  input wire [1:0] voltage_transition_i,
  input wire [1:0] fast_transient_trigger_i,
  // Rail A protection sensing
  input wire [11:0] target_voltage_code_i,
  input wire [11:0] sensed_output_i,
  input wire [11:0] softstart_sense_mv_i,
  input wire [11:0] sum_current_i,
  input wire pwm_pulse_i,
  input wire undervoltage_trip_i,
  // Phase management results
  output reg [2:0] phases_a_o,
  output reg [2:0] phases_b_o,
  output reg [2:0] diode_emulation_o,
  // Power stage drive and flags
  output reg [1:0] pwm_mode_o,
  output reg rail_good_output_o,
  output reg slow_ramp_down_o,
  output reg [1:0] ref_flag_o
);

  // ========================================================================
  // Derived counts
  localparam SETTLE_CYC = `VPM_SETTLE_MASK_US * `VPM_CLK_MHZ;
  localparam SUM_OC_CYC = `VPM_SUM_OC_PERSIST_US * `VPM_CLK_MHZ;
  localparam OV_WAIT_CYC = `VPM_OV_RAMP_WAIT_US * `VPM_CLK_MHZ;
  localparam OV_FILT_CYC = (`VPM_OV_FILTER_NS * `VPM_CLK_MHZ + 999) / 1000;

  // ========================================================================
  // Functions
  function [31:0] shed_cycles;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: shed_cycles = `VPM_SHED_US_0 * `VPM_CLK_MHZ;
        2'h1: shed_cycles = `VPM_SHED_US_1 * `VPM_CLK_MHZ;
        2'h2: shed_cycles = `VPM_SHED_US_2 * `VPM_CLK_MHZ;
        default: shed_cycles = `VPM_SHED_US_3 * `VPM_CLK_MHZ;
      endcase
    end
  endfunction

  // A step stays engaged until current falls below level minus margin.
  function step_on;
    input [7:0] pct;
    input [7:0] lvl;
    input [7:0] mrg;
    input engaged;
    begin
      step_on = (pct > lvl) ||
        (engaged && ({1'b0, pct} + {1'b0, mrg} >= {1'b0, lvl}));
    end
  endfunction

  // ========================================================================
  // Registers
  reg [7:0] add_lvl_a_lo;
  reg [7:0] add_lvl_a_hi;
  reg [7:0] drop_mrg_a_lo;
  reg [7:0] drop_mrg_a_hi;
  reg [7:0] shed_dly_a;
  reg [7:0] add_lvl_b;
  reg [7:0] drop_mrg_b;
  reg [7:0] shed_dly_b;
  reg [2:0] pm_enable;
  reg [7:0] max_current;
  reg [7:0] max_cur_cap;
  reg cap_done;
  reg fault_ss;
  reg fault_soc;
  reg fault_ov;
  reg fault_uv;
  wire fault = fault_ss | fault_soc | fault_ov | fault_uv;

  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      add_lvl_a_lo <= `VPM_RST_ADD_LVL_LO;
      add_lvl_a_hi <= `VPM_RST_ADD_LVL_HI;
      drop_mrg_a_lo <= `VPM_RST_DROP_MRG;
      drop_mrg_a_hi <= `VPM_RST_DROP_MRG;
      shed_dly_a <= `VPM_RST_SHED_DLY;
      add_lvl_b <= `VPM_RST_ADD_LVL_LO;
      drop_mrg_b <= `VPM_RST_DROP_MRG;
      shed_dly_b <= `VPM_RST_SHED_DLY;
      pm_enable <= 3'h7;
      max_current <= `VPM_RST_MAX_CUR;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `VPM_ADDR_ADD_LVL_A_LO: add_lvl_a_lo <= reg_wdata_i;
        `VPM_ADDR_ADD_LVL_A_HI: add_lvl_a_hi <= reg_wdata_i;
        `VPM_ADDR_DROP_MRG_A_LO: drop_mrg_a_lo <= reg_wdata_i;
        `VPM_ADDR_DROP_MRG_A_HI: drop_mrg_a_hi <= reg_wdata_i;
        `VPM_ADDR_SHED_DLY_A: shed_dly_a <= reg_wdata_i;
        `VPM_ADDR_ADD_LVL_B: add_lvl_b <= reg_wdata_i;
        `VPM_ADDR_DROP_MRG_B: drop_mrg_b <= reg_wdata_i;
        `VPM_ADDR_SHED_DLY_B: shed_dly_b <= reg_wdata_i;
        `VPM_ADDR_ENABLE: pm_enable <= reg_wdata_i[2:0];
        `VPM_ADDR_MAX_CUR: max_current <= reg_wdata_i;
        default: pm_enable <= pm_enable;
      endcase
    end
  end

  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `VPM_ADDR_ADD_LVL_A_LO: reg_rdata_o <= add_lvl_a_lo;
        `VPM_ADDR_ADD_LVL_A_HI: reg_rdata_o <= add_lvl_a_hi;
        `VPM_ADDR_DROP_MRG_A_LO: reg_rdata_o <= drop_mrg_a_lo;
        `VPM_ADDR_DROP_MRG_A_HI: reg_rdata_o <= drop_mrg_a_hi;
        `VPM_ADDR_SHED_DLY_A: reg_rdata_o <= shed_dly_a;
        `VPM_ADDR_ADD_LVL_B: reg_rdata_o <= add_lvl_b;
        `VPM_ADDR_DROP_MRG_B: reg_rdata_o <= drop_mrg_b;
        `VPM_ADDR_SHED_DLY_B: reg_rdata_o <= shed_dly_b;
        `VPM_ADDR_ENABLE: reg_rdata_o <= {5'h00, pm_enable};
        `VPM_ADDR_MAX_CUR: reg_rdata_o <= max_current;
        `VPM_ADDR_STATUS: reg_rdata_o <= {phases_a_o[1:0], phases_b_o[1:0],
          fault_ss, fault_soc, fault_ov, fault_uv};
        default: reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // ========================================================================
  // Phase management
  wire full_a = voltage_transition_i[0] | fast_transient_trigger_i[0];
  wire full_b = voltage_transition_i[1] | fast_transient_trigger_i[1];
  wire hi_a = step_on(reported_current_a_i, add_lvl_a_hi, drop_mrg_a_hi,
    phases_a_o >= STEP_HI_A);
  wire lo_a = step_on(reported_current_a_i, add_lvl_a_lo, drop_mrg_a_lo,
    phases_a_o >= STEP_LO_A);
  wire on_b = step_on(reported_current_b_i, add_lvl_b, drop_mrg_b,
    phases_b_o >= FULL_B);
  reg [2:0] want_a;
  reg [2:0] want_b;
  reg [15:0] shed_cnt_a;
  reg [15:0] shed_cnt_b;

  always @* begin
    // Full-phase force
    // (RULE_07) full phase force
    if (full_a) begin
      want_a = FULL_A[2:0];
    end else if (hi_a) begin
      // (RULE_02) threshold step up
      want_a = STEP_HI_A[2:0];
    end else if (lo_a) begin
      want_a = STEP_LO_A[2:0];
    end else begin
      // (RULE_03) hysteresis gated drop
      want_a = 3'h1;
    end
    if (full_b || on_b) begin
      want_b = FULL_B[2:0];
    end else begin
      want_b = 3'h1;
    end
  end

  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phases_a_o <= FULL_A[2:0];
      shed_cnt_a <= 16'h0000;
    end else if (fault) begin
      // (RULE_23) frozen while latched
      shed_cnt_a <= 16'h0000;
    end else if (!pm_enable[0]) begin
      // (RULE_01) disabled rail runs full
      phases_a_o <= FULL_A[2:0];
      shed_cnt_a <= 16'h0000;
    end else if (want_a > phases_a_o) begin
      // (RULE_05) immediate phase add
      phases_a_o <= want_a;
      shed_cnt_a <= 16'h0000;
    end else if (want_a < phases_a_o) begin
      // (RULE_06) delayed phase shed
      if (shed_cnt_a + 16'h0001 >= shed_cycles(shed_dly_a[7:6])) begin
        phases_a_o <= want_a;
        shed_cnt_a <= 16'h0000;
      end else begin
        shed_cnt_a <= shed_cnt_a + 16'h0001;
      end
    end else begin
      shed_cnt_a <= 16'h0000;
    end
  end

  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phases_b_o <= FULL_B[2:0];
      shed_cnt_b <= 16'h0000;
    end else if (!pm_enable[1]) begin
      // (RULE_01) disabled rail runs full
      phases_b_o <= FULL_B[2:0];
      shed_cnt_b <= 16'h0000;
    end else if (want_b > phases_b_o) begin
      // (RULE_05) immediate phase add
      phases_b_o <= want_b;
      shed_cnt_b <= 16'h0000;
    end else if (want_b < phases_b_o) begin
      // (RULE_06) delayed phase shed
      if (shed_cnt_b + 16'h0001 >= shed_cycles(shed_dly_b[7:6])) begin
        phases_b_o <= want_b;
        shed_cnt_b <= 16'h0000;
      end else begin
        shed_cnt_b <= shed_cnt_b + 16'h0001;
      end
    end else begin
      shed_cnt_b <= 16'h0000;
    end
  end

  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      diode_emulation_o <= 3'h0;
    end else begin
      // (RULE_04) diode emulation select
      diode_emulation_o <= pm_enable & zero_current_detect_i;
    end
  end

  // ========================================================================
  // Protection windows for rail A
  wire tgt_zero = (target_voltage_code_i == 12'h000);
  reg first_ramp;
  reg first_done;
  reg ov_start_win;
  reg [15:0] settle_cnt;
  wire in_settle = (settle_cnt != 16'h0000);

  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      first_ramp <= 1'b0;
      first_done <= 1'b0;
      ov_start_win <= 1'b0;
      settle_cnt <= 16'h0000;
    end else begin
      if (voltage_transition_i[0]) begin
        settle_cnt <= SETTLE_CYC[15:0];
      end else if (in_settle) begin
        settle_cnt <= settle_cnt - 16'h0001;
      end
      if (tgt_zero && !voltage_transition_i[0]) begin
        ov_start_win <= 1'b0;
      end else if (voltage_transition_i[0] && tgt_zero) begin
        ov_start_win <= 1'b1;
      end else if (!voltage_transition_i[0] && pwm_pulse_i) begin
        // (RULE_17) window ends on first pulse
        ov_start_win <= 1'b0;
      end
      if (!first_done && voltage_transition_i[0]) begin
        first_ramp <= 1'b1;
      end else if (first_ramp && !voltage_transition_i[0] && !in_settle) begin
        first_ramp <= 1'b0;
        first_done <= 1'b1;
      end
    end
  end

  // ========================================================================
  // Soft-start and sum overcurrent
  reg [31:0] ss_base;
  wire [19:0] ss_lhs = softstart_sense_mv_i * max_current;
  wire [31:0] ss_rhs = ss_base * `VPM_SS_SCALE * phases_a_o;
  wire ss_hit = ss_lhs > ss_rhs;
  // (RULE_12) sum overcurrent factor
  wire [31:0] soc_k = (max_cur_cap >= `VPM_SS_BAND_LO_A) ?
    `VPM_SOC_K_HI_X10 : `VPM_SOC_K_LO_X10;
  wire [19:0] soc_lhs = (phases_a_o == FULL_A ||
    max_cur_cap < `VPM_SS_BAND_LO_A) ?
    sum_current_i * 4'ha : sum_current_i * 4'ha * phases_a_o;
  wire soc_hit = soc_lhs > soc_k * max_cur_cap;
  wire soc_mask = voltage_transition_i[0] | in_settle | tgt_zero;
  reg [15:0] soc_cnt;

  always @* begin
    // (RULE_10) threshold band select
    if (max_current < `VPM_SS_BAND_LO_A) begin
      ss_base = `VPM_SS_BASE_LO_MV;
    end else if (max_current < `VPM_SS_BAND_HI_A) begin
      ss_base = `VPM_SS_BASE_MID_MV;
    end else begin
      ss_base = `VPM_SS_BASE_HI_MV;
    end
  end

  // ========================================================================
  // Overvoltage
  wire [31:0] ov_rel = target_voltage_code_i + `VPM_OV_MARGIN_MV;
  // (RULE_18) relative overvoltage level
  wire [31:0] ov_lvl = ov_start_win ? `VPM_OV_START_MV :
    (target_voltage_code_i > `VPM_OV_KNEE_MV) ? ov_rel : `VPM_OV_FLOOR_MV;
  wire ov_hit = !tgt_zero && (sensed_output_i > ov_lvl);
  reg [7:0] ov_filt;
  reg [15:0] ov_wait;
  reg ov_hold;
  reg ov_from_start;

  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      max_cur_cap <= 8'h00;
      cap_done <= 1'b0;
      fault_ss <= 1'b0;
      fault_soc <= 1'b0;
      fault_ov <= 1'b0;
      fault_uv <= 1'b0;
      soc_cnt <= 16'h0000;
      ov_filt <= 8'h00;
      ov_wait <= 16'h0000;
      ov_hold <= 1'b0;
      ov_from_start <= 1'b0;
      slow_ramp_down_o <= 1'b0;
    end else if (!enable_i) begin
      // (RULE_11) enable low clears latches
      fault_ss <= 1'b0;
      fault_soc <= 1'b0;
      fault_ov <= 1'b0;
      fault_uv <= 1'b0;
      soc_cnt <= 16'h0000;
      ov_filt <= 8'h00;
      ov_hold <= 1'b0;
      slow_ramp_down_o <= 1'b0;
      cap_done <= 1'b0;
    end else begin
      // (RULE_13) capture once per enable
      if (!cap_done) begin
        max_cur_cap <= max_current;
        cap_done <= 1'b1;
      end
      // (RULE_08) soft-start detection window
      if ((first_ramp || in_settle && !first_done) && ss_hit && !fault) begin
        fault_ss <= 1'b1;
      end
      // (RULE_15) masked persistence count
      if (soc_mask || !soc_hit || !cap_done) begin
        soc_cnt <= 16'h0000;
      end else if (soc_cnt + 16'h0001 >= SUM_OC_CYC[15:0]) begin
        // (RULE_14) persistent sum overcurrent
        if (!fault) begin
          fault_soc <= 1'b1;
        end
      end else begin
        soc_cnt <= soc_cnt + 16'h0001;
      end
      if (undervoltage_trip_i && !fault) begin
        fault_uv <= 1'b1;
      end
      // (RULE_16) detection off at zero target
      if (!ov_hit || fault) begin
        ov_filt <= 8'h00;
      end else if (ov_filt + 8'h01 >= OV_FILT_CYC[7:0]) begin
        // (RULE_19) filtered overvoltage trip
        fault_ov <= 1'b1;
        ov_hold <= 1'b1;
        ov_from_start <= ov_start_win;
        ov_wait <= 16'h0000;
      end else begin
        ov_filt <= ov_filt + 8'h01;
      end
      if (fault_ov) begin
        // (RULE_20) release level by start condition
        if (ov_from_start ? (sensed_output_i < `VPM_OV_RELEASE_MV) :
            (sensed_output_i < target_voltage_code_i)) begin
          ov_hold <= 1'b0;
        end
        // (RULE_21) slow ramp after wait
        if (ov_wait + 16'h0001 >= OV_WAIT_CYC[15:0]) begin
          slow_ramp_down_o <= 1'b1;
        end else begin
          ov_wait <= ov_wait + 16'h0001;
        end
      end
    end
  end

  // ========================================================================
  // Stage drive, rail good and flag
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pwm_mode_o <= `VPM_PWM_TRI;
      rail_good_output_o <= 1'b0;
      ref_flag_o <= `VPM_FLAG_NONE;
    end else begin
      // (RULE_23) latched faults hold rail not good
      rail_good_output_o <= enable_i && !fault;
      if (fault_ov) begin
        // (RULE_21) no turn-on, track target down
        if (ov_hold || sensed_output_i > target_voltage_code_i) begin
          pwm_mode_o <= `VPM_PWM_LOW;
        end else begin
          pwm_mode_o <= `VPM_PWM_TRI;
        end
      end else if (fault_ss || fault_soc || fault_uv || !enable_i) begin
        // (RULE_09) all switches off
        pwm_mode_o <= `VPM_PWM_TRI;
      end else begin
        pwm_mode_o <= `VPM_PWM_RUN;
      end
      // (RULE_22) flag level per fault
      if (fault_ov) begin
        ref_flag_o <= `VPM_FLAG_OV;
      end else if (fault_uv) begin
        ref_flag_o <= `VPM_FLAG_UV;
      end else if (fault_ss || fault_soc) begin
        ref_flag_o <= `VPM_FLAG_OC;
      end else begin
        ref_flag_o <= `VPM_FLAG_NONE;
      end
    end
  end

endmodule

// File: hw/vpm_consts.vh
// Constants for the phase management and fault protection block.
`ifndef VPM_CONSTS_VH
`define VPM_CONSTS_VH
// ==========================================================================
// Register offsets
`define VPM_ADDR_ADD_LVL_A_LO 8'h92
`define VPM_ADDR_ADD_LVL_A_HI 8'h93
`define VPM_ADDR_DROP_MRG_A_LO 8'h94
`define VPM_ADDR_DROP_MRG_A_HI 8'h95
`define VPM_ADDR_SHED_DLY_A 8'h96
`define VPM_ADDR_ADD_LVL_B 8'h99
`define VPM_ADDR_DROP_MRG_B 8'h9a
`define VPM_ADDR_SHED_DLY_B 8'h9b
`define VPM_ADDR_ENABLE 8'ha0
`define VPM_ADDR_MAX_CUR 8'ha1
`define VPM_ADDR_STATUS 8'ha2
// ==========================================================================
// Field positions and reset values
`define VPM_SHED_SEL_HI 7
`define VPM_SHED_SEL_LO 6
`define VPM_RST_ADD_LVL_LO 8'h28
`define VPM_RST_ADD_LVL_HI 8'h3c
`define VPM_RST_DROP_MRG 8'h05
`define VPM_RST_SHED_DLY 8'h00
`define VPM_RST_ENABLE 8'h07
`define VPM_RST_MAX_CUR 8'h40
// ==========================================================================
// Timing, in microseconds and nanoseconds at the clock rate in MHz
`define VPM_CLK_MHZ 20
`define VPM_SETTLE_MASK_US 80
`define VPM_SUM_OC_PERSIST_US 40
`define VPM_OV_RAMP_WAIT_US 60
`define VPM_OV_FILTER_NS 500
`define VPM_SHED_US_0 10
`define VPM_SHED_US_1 20
`define VPM_SHED_US_2 50
`define VPM_SHED_US_3 100
// ==========================================================================
// Protection levels, in mV, A and tenths
`define VPM_SS_BAND_LO_A 40
`define VPM_SS_BAND_HI_A 80
`define VPM_SS_BASE_LO_MV 200
`define VPM_SS_BASE_MID_MV 400
`define VPM_SS_BASE_HI_MV 800
`define VPM_SS_SCALE 70
`define VPM_SOC_K_HI_X10 13
`define VPM_SOC_K_LO_X10 16
`define VPM_OV_START_MV 2450
`define VPM_OV_MARGIN_MV 350
`define VPM_OV_KNEE_MV 1000
`define VPM_OV_FLOOR_MV 1350
`define VPM_OV_RELEASE_MV 2100
// ==========================================================================
// Flag and drive codes
`define VPM_FLAG_NONE 2'h0
`define VPM_FLAG_OV 2'h1
`define VPM_FLAG_UV 2'h2
`define VPM_FLAG_OC 2'h3
`define VPM_PWM_RUN 2'h0
`define VPM_PWM_LOW 2'h1
`define VPM_PWM_TRI 2'h2
`endif

// File: sim/vpm_ctrl_assertions.sv
// Checker for the phase management and protection control block.
`timescale 1ns/1ns
module vpm_ctrl_checker (
  // Clock and reset
  input wire ref_clk_i,
  input wire arst_n_i,
  // Watched inputs
  input wire enable_i,
  input wire [2:0] zero_current_detect_i,
  input wire [1:0] voltage_transition_i,
  input wire [1:0] fast_transient_trigger_i,
  input wire [11:0] target_voltage_code_i,
  input wire [11:0] sensed_output_i,
  // Watched outputs
  input wire [2:0] phases_a_o,
  input wire [2:0] phases_b_o,
  input wire [2:0] diode_emulation_o,
  input wire [1:0] pwm_mode_o,
  input wire rail_good_output_o,
  input wire slow_ramp_down_o,
  input wire [1:0] ref_flag_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!arst_n_i);
  // ==========
  // Age of a latched overvoltage fault
  reg [11:0] ov_age;
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ov_age <= 12'h000;
    end else if (ref_flag_o != 2'h1) begin
      ov_age <= 12'h000;
    end else if (ov_age != 12'hfff) begin
      ov_age <= ov_age + 12'h001;
    end
  end
  // ==========
  // Properties
  a_ov_zero_mask: assert property (
    $rose(ref_flag_o == 2'h1) |-> $past(target_voltage_code_i, 2) != 0
  ) else $error("overvoltage trip with zero target");
  a_ov_filter: assert property (
    $rose(ref_flag_o == 2'h1) |-> $past(sensed_output_i, 10) > 12'd1350
  ) else $error("overvoltage trip without filtered cause");
  a_ov_action: assert property (
    $rose(ref_flag_o == 2'h1) |-> pwm_mode_o == 2'h1 && !rail_good_output_o
  ) else $error("overvoltage action wrong");
  a_oc_action: assert property (
    $rose(ref_flag_o == 2'h3) |-> pwm_mode_o == 2'h2 && !rail_good_output_o
  ) else $error("overcurrent action wrong");
  a_flag_latched: assert property (
    ref_flag_o != 2'h0 && enable_i |=> $stable(ref_flag_o)
  ) else $error("fault flag left its latch");
  a_ov_no_run: assert property (
    ref_flag_o == 2'h1 |-> pwm_mode_o != 2'h0
  ) else $error("switching resumed after overvoltage");
  a_ramp_wait: assert property (
    ref_flag_o == 2'h1 && ov_age < 12'd1180 |-> !slow_ramp_down_o
  ) else $error("slow ramp started early");
  a_ramp_start: assert property (
    enable_i && ov_age > 12'd1215 |-> slow_ramp_down_o
  ) else $error("slow ramp missing");
  a_full_on_trans: assert property (
    voltage_transition_i[0] && ref_flag_o == 2'h0
      |=> phases_a_o == 3'd5 || ref_flag_o != 2'h0
  ) else $error("rail A not full on transition");
  a_full_b_fast: assert property (
    fast_transient_trigger_i[1] |=> phases_b_o == 3'd2
  ) else $error("rail B not full on fast transient");
  a_dem_subset: assert property (
    (diode_emulation_o & ~$past(zero_current_detect_i)) == 3'h0
  ) else $error("diode emulation without zero current");
  c_ov: cover property ($rose(ref_flag_o == 2'h1));
  c_oc: cover property ($rose(ref_flag_o == 2'h3));
  c_shed: cover property (phases_a_o < $past(phases_a_o));
endmodule

// File: sim/vpm_stage_model.sv
// Behavioural model of the rail A power stages and output sense.
`timescale 1ns/1ns
module vpm_stage_model (
  // Clock and reset
  input wire ref_clk_i,
  input wire arst_n_i,
  // Drive from the controller and the bench
  input wire [1:0] pwm_mode_i,
  input wire [11:0] target_mv_i,
  input wire [11:0] excess_mv_i,
  // Sensed output voltage
  output reg [11:0] sensed_mv_o
);
  // Low-side switches on drain the output; otherwise it follows the
  // target plus any excess the bench injects.
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sensed_mv_o <= 12'h000;
    end else if (pwm_mode_i == 2'h1) begin
      sensed_mv_o <= (sensed_mv_o > 12'd20) ? sensed_mv_o - 12'd20 : 12'h000;
    end else begin
      sensed_mv_o <= target_mv_i + excess_mv_i;
    end
  end
endmodule

// File: sim/vpm_ctrl_tb.sv
// Self-checking bench for the phase management and protection block.
`timescale 1ns/1ns
module vpm_ctrl_tb;
  reg ref_clk_i = 1'b0;
  reg arst_n_i = 1'b0;
  reg [7:0] addr = 8'h00;
  reg [7:0] wdata = 8'h00;
  reg wr_s = 1'b0;
  reg rd_s = 1'b0;
  reg enable = 1'b1;
  reg [7:0] cur_a = 8'h00;
  reg [7:0] cur_b = 8'h00;
  reg [2:0] zero_current_detect = 3'h0;
  reg [1:0] trans = 2'h0;
  reg [1:0] fast = 2'h0;
  reg [11:0] target = 12'h000;
  reg [11:0] excess = 12'h000;
  reg [11:0] sum_cur = 12'h000;
  reg pulse = 1'b0;
  reg uv = 1'b0;
  reg [11:0] ss_sense = 12'h000;
  wire [7:0] rdata;
  wire [11:0] sensed;
  wire [2:0] ph_a;
  wire [2:0] ph_b;
  wire [2:0] diode_emulation;
  wire [1:0] pwm;
  wire [1:0] flag;
  wire good;
  wire slow;
  wire [11:0] prot = {7'h0, flag, pwm, good};
  integer fail_count = 0;
  integer comparisons = 0;
  integer i;
  reg [31:0] rows [0:7];
  always #25 ref_clk_i = ~ref_clk_i;
  vpm_ctrl vpm_ctrl_inst (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr_s),
    .reg_rd_i(rd_s), .reg_rdata_o(rdata), .enable_i(enable),
    .reported_current_a_i(cur_a), .reported_current_b_i(cur_b),
    .zero_current_detect_i(zero_current_detect), .voltage_transition_i(trans),
    .fast_transient_trigger_i(fast), .target_voltage_code_i(target),
    .sensed_output_i(sensed), .softstart_sense_mv_i(ss_sense),
    .sum_current_i(sum_cur), .pwm_pulse_i(pulse),
    .undervoltage_trip_i(uv), .phases_a_o(ph_a), .phases_b_o(ph_b),
    .diode_emulation_o(diode_emulation), .pwm_mode_o(pwm),
    .rail_good_output_o(good), .slow_ramp_down_o(slow), .ref_flag_o(flag)
  );
  vpm_stage_model vpm_stage_model_inst (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .pwm_mode_i(pwm),
    .target_mv_i(target), .excess_mv_i(excess), .sensed_mv_o(sensed)
  );
  // ==========
  // Shared tasks
  task chk(input [11:0] got, input [11:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge ref_clk_i);
      wr_s <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge ref_clk_i);
      wr_s <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] exp);
    begin
      @(posedge ref_clk_i);
      rd_s <= 1'b1;
      addr <= a;
      @(posedge ref_clk_i);
      rd_s <= 1'b0;
      @(negedge ref_clk_i);
      chk({4'h0, rdata}, {4'h0, exp});
    end
  endtask
  // Only a drop of the enable clears a latched fault.
  task recover;
    begin
      @(posedge ref_clk_i);
      enable <= 1'b0;
      cyc(2);
      @(posedge ref_clk_i);
      enable <= 1'b1;
      cyc(3);
    end
  endtask
  task close_out;
    begin
      $display("checks=%0d mismatches=%0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
        $display("Regression OK");
      end else begin
        $display("Regression broken");
      end
      $finish;
    end
  endtask
  initial begin
    #1500000;
    fail_count = fail_count + 1;
    close_out;
  end
  // ==========
  // Main sequence
  initial begin
    rows[0] = 32'h92282828;
    rows[1] = 32'h933c3c3c;
    rows[2] = 32'h94050505;
    rows[3] = 32'h95050505;
    rows[4] = 32'h96004040;
    rows[5] = 32'h9b008080;
    rows[6] = 32'ha1404040;
    rows[7] = 32'h5000ff00;
    cyc(3);
    chk({ph_a, ph_b, prot[4:0], slow}, 12'ha88);
    @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      rd(rows[i][31:24], rows[i][23:16]);
      wr(rows[i][31:24], rows[i][15:8]);
      rd(rows[i][31:24], rows[i][7:0]);
    end
    cyc(1000);
    chk({11'h0, ph_a < 3'd4}, 12'h001);
    @(posedge ref_clk_i);
    cur_a <= 8'd60;
    cyc(3);
    chk({11'h0, ph_a < 3'd4}, 12'h001);
    @(posedge ref_clk_i);
    cur_a <= 8'd61;
    cyc(1);
    chk({9'h0, ph_a}, 12'd4);
    @(posedge ref_clk_i);
    cur_a <= 8'd56;
    cyc(600);
    chk({9'h0, ph_a}, 12'd4);
    @(posedge ref_clk_i);
    cur_a <= 8'd54;
    cyc(390);
    chk({9'h0, ph_a}, 12'd4);
    cyc(20);
    chk({11'h0, ph_a < 3'd4}, 12'h001);
    chk({9'h0, ph_b}, 12'd1);
    @(posedge ref_clk_i);
    trans <= 2'h1;
    fast <= 2'h2;
    cyc(1);
    chk({6'h0, ph_a, ph_b}, 12'h02a);
    ss_sense <= 12'd2200;
    cyc(2);
    chk(prot, 12'h01c);
    ss_sense <= 12'd0;
    recover;
    @(posedge ref_clk_i);
    trans <= 2'h0;
    fast <= 2'h0;
    cyc(2000);
    wr(8'ha0, 8'h06);
    zero_current_detect <= 3'h7;
    cyc(2);
    chk({6'h0, ph_a, diode_emulation}, 12'h02e);
    wr(8'ha0, 8'h07);
    cyc(2);
    chk({9'h0, diode_emulation}, 12'h007);
    zero_current_detect <= 3'h0;
    excess <= 12'd2600;
    cyc(30);
    chk(prot, 12'h001);
    @(posedge ref_clk_i);
    trans <= 2'h1;
    @(posedge ref_clk_i);
    target <= 12'd1200;
    excess <= 12'd800;
    cyc(40);
    trans <= 2'h0;
    cyc(20);
    chk({10'h0, flag}, 12'h000);
    pulse <= 1'b1;
    excess <= 12'd0;
    @(posedge ref_clk_i);
    pulse <= 1'b0;
    cyc(5);
    excess <= 12'd400;
    cyc(8);
    excess <= 12'd0;
    cyc(20);
    chk({10'h0, flag}, 12'h000);
    excess <= 12'd400;
    cyc(14);
    chk(prot, 12'h00a);
    excess <= 12'd0;
    cyc(1250);
    chk({9'h0, flag, slow}, 12'h003);
    recover;
    chk({10'h0, flag}, 12'h000);
    trans <= 2'h1;
    fast <= 2'h1;
    sum_cur <= 12'd90;
    cyc(1000);
    trans <= 2'h0;
    cyc(1500);
    chk({10'h0, flag}, 12'h000);
    sum_cur <= 12'd80;
    wr(8'ha1, 8'h10);
    cyc(900);
    chk({10'h0, flag}, 12'h000);
    sum_cur <= 12'd84;
    cyc(790);
    chk({10'h0, flag}, 12'h000);
    cyc(20);
    chk(prot, 12'h01c);
    sum_cur <= 12'd0;
    fast <= 2'h0;
    wr(8'ha1, 8'h40);
    recover;
    uv <= 1'b1;
    cyc(3);
    chk({10'h0, flag}, 12'h002);
    uv <= 1'b0;
    recover;
    chk({10'h0, flag}, 12'h000);
    close_out;
  end
endmodule
bind vpm_ctrl vpm_ctrl_checker vpm_ctrl_checker_inst (
  .ref_clk_i, .arst_n_i, .enable_i, .zero_current_detect_i,
  .voltage_transition_i, .fast_transient_trigger_i,
  .target_voltage_code_i, .sensed_output_i, .phases_a_o, .phases_b_o,
  .diode_emulation_o, .pwm_mode_o, .rail_good_output_o,
  .slow_ramp_down_o, .ref_flag_o
);
